// [rtl/pmc_consts.vh]
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH
// Register byte offsets
`define PMC_OFF_MODE 12'h000
`define PMC_OFF_PWREN 12'h004
`define PMC_OFF_DIV 12'h008
`define PMC_OFF_EXTCFG 12'h00C
`define PMC_OFF_MAP 12'h010
`define PMC_OFF_WAKEEN 12'h014
`define PMC_OFF_STATUS 12'h018
// Mode register bits
`define PMC_MODE_IDLE 0
`define PMC_MODE_PDOWN 1
// External config field position of the polarity bits
`define PMC_POL_LSB 16
// Divider encodings
`define PMC_DIV_W 2
`define PMC_DIV_FULL 2'h1
`define PMC_DIV_HALF 2'h2
`define PMC_DIV_QUARTER 2'h0
// Last divider count at quarter rate
`define PMC_DIV_LIM_QUARTER 2'h3
// Reset values
`define PMC_PWREN_RST 32'hFFFF_FFFF
`define PMC_ZERO 32'h0000_0000
// Vector map encodings
`define PMC_MAP_FLASH 1'b0
`define PMC_MAP_SRAM 1'b1
`endif

// [rtl/pmc_top.v]
// Contract
// R1 - Idle halts processor until reset or interrupt.
// R2 - Peripheral clock keeps running in idle; peripheral interrupt ends idle.
// R3 - Idle gates clocks of processor, memories and internal buses.
// R4 - Power-down stops the oscillator; no internal clock toggles.
// R5 - Power-down keeps all state and holds output pins static.
// R6 - Power-down left only by reset or clockless interrupt.
// R7 - Each power-down wake passes the oscillator wake-up timer.
// R8 - One enable per peripheral; clearing it switches that one off.
// R9 - Peripheral clock divides processor clock by one, two or four.
// R10 - After reset the peripheral clock is one quarter rate.
// R11 - A running PLL stays active during idle.
// R12 - Nine external interrupt pins, edge or level, merge to four lines.
// R13 - A configured external interrupt wakes from power-down.
// R14 - Vector region at zero maps to flash or SRAM.
// R15 - Divider ratio changes never produce a short peripheral pulse.
`timescale 1ns/1ps
`include "pmc_consts.vh"
module pmc_top #(
  parameter NPERIPH = 32,
  parameter NEXT = 9,
  parameter WAKE_CYCLES = 16
) (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt sources
  input wire periph_irq,
  input wire [NEXT-1:0] ext_pin,
  // PLL state
  input wire pll_running,
  // Clock and power controls
  output reg cpu_clk_en,
  output reg mem_bus_clk_en,
  output reg osc_en,
  output reg pll_keep,
  output reg pin_hold,
  output reg periph_clk_en,
  output reg [NPERIPH-1:0] periph_pwr_en,
  output reg [3:0] ext_irq,
  output reg vec_map_sram
);

  localparam ST_RUN = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_PDOWN = 2'h2;
  localparam ST_WAKE = 2'h3;

  // Power mode state
  reg [1:0] state;

  // Peripheral clock ratio, phase counter and the ratio in force
  reg [1:0] div_sel;
  reg [1:0] div_cnt;
  reg [1:0] div_lim_cur;

  // External pin sense configuration and last sampled levels
  reg [NEXT-1:0] ext_edge;
  reg [NEXT-1:0] ext_pol;
  reg [NEXT-1:0] ext_prev;

  // Wake-up line enables and oscillator settle counter
  reg [3:0] wake_en;
  reg [15:0] wake_cnt;

  // Combinational results
  reg [3:0] next_ext_irq;
  reg [1:0] div_limit;
  integer i;

  // Bus phase decode: writes land in the access phase, reads decode in setup
  wire wr = psel & penable & pwrite;
  wire rd_setup = psel & ~penable;

  // Pin to line merge: pin i feeds line i mod 4
  function [3:0] merge;
    input [NEXT-1:0] act;
    integer k;
    begin
      merge = 4'h0;
      for (k = 0; k < NEXT; k = k + 1) begin
        merge[k % 4] = merge[k % 4] | act[k];
      end
    end
  endfunction

  // Last count value for a ratio
  function [1:0] limit_of;
    input [1:0] sel;
    begin
      if (sel == `PMC_DIV_FULL) begin
        limit_of = 2'h0;
      end else if (sel == `PMC_DIV_HALF) begin
        limit_of = 2'h1;
      end else begin
        limit_of = 2'h3;
      end
    end
  endfunction

  // External pin activity, edge or level per pin
  always @* begin : ext_detect
    reg [NEXT-1:0] act;
    act = {NEXT{1'b0}};
    for (i = 0; i < NEXT; i = i + 1) begin
      if (ext_edge[i]) begin
        // Edge mode: a change onto the active level
        act[i] = (ext_pin[i] ^ ext_prev[i]) & ~(ext_pin[i] ^ ext_pol[i]);
      end else begin
        // Level mode: pin sits at the active level
        act[i] = ~(ext_pin[i] ^ ext_pol[i]);
      end
    end
    // R12 merge to four
    next_ext_irq = merge(act);
    div_limit = limit_of(div_sel);
  end

  // Settle counter has reached its last value
  wire wake_done = (wake_cnt == WAKE_CYCLES - 1);
  // Clockless wake request: an enabled line on which any one pin matches its polarity
  wire pdown_wake = |(merge(ext_pin ~^ ext_pol) & wake_en);

  // APB answer: ready one cycle after setup, read data decoded in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `PMC_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= 1'b0;
      if (rd_setup) begin
        prdata <= `PMC_ZERO;
        if (paddr == `PMC_OFF_MODE) begin
          // Mode register reads back the current mode
          prdata <= {30'h0000_0000, state == ST_PDOWN, state == ST_IDLE};
        end else if (paddr == `PMC_OFF_PWREN) begin
          // Peripheral power enables
          prdata <= periph_pwr_en;
        end else if (paddr == `PMC_OFF_DIV) begin
          // Ratio select as written
          prdata <= {30'h0000_0000, div_sel};
        end else if (paddr == `PMC_OFF_EXTCFG) begin
          // Polarity and edge mode per pin
          prdata <= {7'h00, ext_pol, 7'h00, ext_edge};
        end else if (paddr == `PMC_OFF_MAP) begin
          // Vector map select
          prdata <= {31'h0000_0000, vec_map_sram};
        end else if (paddr == `PMC_OFF_WAKEEN) begin
          // Wake line enables
          prdata <= {28'h000_0000, wake_en};
        end else if (paddr == `PMC_OFF_STATUS) begin
          // Merged interrupt lines
          prdata <= {28'h000_0000, ext_irq};
        end else begin
          // Unmapped offset is refused
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Register writes, taken at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // R8 all peripherals powered at reset
      periph_pwr_en <= {NPERIPH{1'b1}};
      // R10 quarter rate at reset
      div_sel <= `PMC_DIV_QUARTER;
      // Level sense, low polarity at reset
      ext_edge <= {NEXT{1'b0}};
      ext_pol <= {NEXT{1'b0}};
      wake_en <= 4'h0;
      // R14 vectors from flash at reset
      vec_map_sram <= `PMC_MAP_FLASH;
    end else if (wr && pready) begin
      if (paddr == `PMC_OFF_PWREN) begin
        // R8 per-peripheral enable
        periph_pwr_en <= pwdata[NPERIPH-1:0];
      end else if (paddr == `PMC_OFF_DIV) begin
        // R9 ratio select
        div_sel <= pwdata[1:0];
      end else if (paddr == `PMC_OFF_EXTCFG) begin
        // R12 per-pin edge or level and polarity
        ext_edge <= pwdata[NEXT-1:0];
        ext_pol <= pwdata[`PMC_POL_LSB+NEXT-1:`PMC_POL_LSB];
      end else if (paddr == `PMC_OFF_MAP) begin
        // R14 vector map select
        vec_map_sram <= pwdata[0];
      end else if (paddr == `PMC_OFF_WAKEEN) begin
        // R13 wake line enables
        wake_en <= pwdata[3:0];
      end
    end
  end

  // External pin history and merged interrupt lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= {NEXT{1'b0}};
      ext_irq <= 4'h0;
    end else begin
      // Edge mode compares against this
      ext_prev <= ext_pin;
      // R12 four registered request lines
      ext_irq <= next_ext_irq;
    end
  end

  // Power mode sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      wake_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_RUN: begin
          // Mode write: power-down wins over idle
          if (wr && pready && paddr == `PMC_OFF_MODE) begin
            if (pwdata[`PMC_MODE_PDOWN]) begin
              // R4 enter power-down
              state <= ST_PDOWN;
            end else if (pwdata[`PMC_MODE_IDLE]) begin
              // R1 enter idle
              state <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          // R1 R2 any interrupt resumes, else stay halted
          if (periph_irq || (|next_ext_irq)) begin
            state <= ST_RUN;
          end
        end
        ST_PDOWN: begin
          // R6 R13 clockless wake
          if (pdown_wake) begin
            state <= ST_WAKE;
            wake_cnt <= 16'h0000;
          end
        end
        default: begin
          // R7 oscillator settle
          if (wake_done) begin
            state <= ST_RUN;
          end else begin
            wake_cnt <= wake_cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // Clock and pin gating per power mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      mem_bus_clk_en <= 1'b1;
      osc_en <= 1'b1;
      pll_keep <= 1'b0;
      pin_hold <= 1'b0;
    end else begin
      // R3 idle clock removal
      cpu_clk_en <= (state == ST_RUN);
      mem_bus_clk_en <= (state == ST_RUN);
      // R4 oscillator off
      osc_en <= (state != ST_PDOWN);
      // R11 PLL kept in idle
      pll_keep <= pll_running & (state != ST_PDOWN);
      // R5 freeze pins and state
      pin_hold <= (state == ST_PDOWN) || (state == ST_WAKE);
    end
  end

  // Peripheral clock enable divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= 1'b0;
      div_cnt <= 2'h0;
      // R10 quarter-rate ratio in force at reset
      div_lim_cur <= `PMC_DIV_LIM_QUARTER;
    end else begin
      // R2 R9 divider runs in run and idle
      if (state == ST_PDOWN || state == ST_WAKE) begin
        periph_clk_en <= 1'b0;
      end else if (div_cnt >= div_lim_cur) begin
        // R15 new ratio taken only at period end
        div_cnt <= 2'h0;
        div_lim_cur <= div_limit;
        periph_clk_en <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 2'h1;
        periph_clk_en <= 1'b0;
      end
    end
  end

endmodule // pmc_top

// [test/pmc_top_asserts.sv]
`timescale 1ns/1ps
module pmc_top_asserts (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Clock and power controls
  input wire pll_running,
  input wire cpu_clk_en,
  input wire mem_bus_clk_en,
  input wire osc_en,
  input wire pll_keep,
  input wire pin_hold,
  input wire periph_clk_en
);
  default clocking pmc_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  clk_pair_a:
    assert property (cpu_clk_en == mem_bus_clk_en) else $error("gates split");
  pdown_stop_a:
    assert property (!osc_en && !$past(osc_en) |-> !cpu_clk_en && !periph_clk_en && pin_hold)
    else $error("clock in power-down");
  hold_halt_a:
    assert property (pin_hold |-> !cpu_clk_en) else $error("run while held");
  wake_timer_a:
    assert property ($rose(osc_en) |-> !cpu_clk_en [*3] ##[1:60] cpu_clk_en)
    else $error("wake timing");
  pll_idle_a:
    assert property (osc_en && $past(osc_en) && $past(pll_running) |-> pll_keep)
    else $error("pll dropped");
endmodule // pmc_top_asserts
bind pmc_top pmc_top_asserts pmc_chk (.*);

// [test/pmc_core_model.sv]
`timescale 1ns/1ps
module pmc_core_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Core side
  input wire raise,
  input wire cpu_clk_en,
  output reg periph_irq,
  output reg pll_running
);
  // Irq held until the core runs; PLL locks after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq <= 1'b0;
      pll_running <= 1'b0;
    end else begin
      pll_running <= 1'b1;
      if (raise) periph_irq <= 1'b1;
      else if (cpu_clk_en) periph_irq <= 1'b0;
    end
  end
endmodule // pmc_core_model

// [test/pmc_top_tb_top.sv]
`timescale 1ns/1ps
`include "pmc_consts.vh"
module pmc_top_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, raise = 0, err;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [8:0] ext_pin = 0;
  integer err_count = 0, checks_done = 0, p, i;
  wire [31:0] prdata, periph_pwr_en;
  wire [3:0] ext_irq;
  wire pready, pslverr, periph_irq, pll_running, cpu_clk_en, mem_bus_clk_en;
  wire osc_en, pll_keep, pin_hold, periph_clk_en, vec_map_sram;
  always #5 pclk = ~pclk;
  pmc_top #(.WAKE_CYCLES(4)) dut (.*);
  pmc_core_model core (.*);
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Bounded wait on an edge
  task tick(input integer lim);
    begin
      p = p + 1;
      if (p > lim) begin
        err_count = err_count + 1;
        wrap_up;
      end
      @(posedge pclk);
    end
  endtask
  // One APB transfer, held until pready
  task apb(input wr, input [11:0] a, input [31:0] d);
    begin
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      p = 0;
      tick(20);
      while (pready !== 1'b1) tick(20);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask
  // Cycles between two peripheral clock pulses
  task period;
    begin
      p = 0;
      while (periph_clk_en !== 1'b1) tick(20);
      p = 0;
      tick(20);
      while (periph_clk_en !== 1'b1) tick(20);
    end
  endtask
  task wait_cpu;
    begin
      p = 0;
      while (cpu_clk_en !== 1'b1) tick(200);
    end
  endtask
  task t_div;
    begin
      apb(0, `PMC_OFF_DIV, 0);
      check(rd, `PMC_DIV_QUARTER);
      period;
      check(p, 4);
      for (i = 1; i < 4; i = i + 1) begin
        apb(1, `PMC_OFF_DIV, i);
        period;
        period;
        check(p, i == 3 ? 4 : i);
      end
      $display("divider test done");
    end
  endtask
  task t_regs;
    begin
      check(periph_pwr_en, `PMC_PWREN_RST);
      apb(1, `PMC_OFF_PWREN, 32'hFFFF_FFFE);
      check(periph_pwr_en, 32'hFFFF_FFFE);
      apb(1, `PMC_OFF_PWREN, `PMC_PWREN_RST);
      for (i = 1; i >= 0; i = i - 1) begin
        apb(1, `PMC_OFF_MAP, i);
        check(vec_map_sram, i);
      end
      apb(0, 12'h100, 0);
      check({31'h0000_0000, err}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
      $display("register test done");
    end
  endtask
  task t_idle;
    begin
      apb(1, `PMC_OFF_EXTCFG, 32'h01FF_0000);
      apb(1, `PMC_OFF_MODE, 32'h1);
      repeat (2) @(posedge pclk);
      check({cpu_clk_en, mem_bus_clk_en, osc_en, pll_keep}, 4'h3);
      period;
      check(p, 4);
      raise <= 1;
      @(posedge pclk);
      raise <= 0;
      wait_cpu;
      apb(0, `PMC_OFF_MODE, 0);
      check(rd, 0);
      $display("idle test done");
    end
  endtask
  task t_pdown;
    begin
      apb(1, `PMC_OFF_EXTCFG, 32'h01FF_0000);
      ext_pin <= 9'h020;
      repeat (3) @(posedge pclk);
      check(ext_irq, 4'h2);
      apb(0, `PMC_OFF_STATUS, 0);
      check(rd, 32'h0000_0002);
      ext_pin <= 9'h000;
      apb(1, `PMC_OFF_WAKEEN, 32'h2);
      apb(1, `PMC_OFF_MODE, 32'h2);
      repeat (20) @(posedge pclk);
      check({osc_en, cpu_clk_en, periph_clk_en, pll_keep, pin_hold}, 5'h01);
      check(periph_pwr_en, `PMC_PWREN_RST);
      ext_pin <= 9'h020;
      wait_cpu;
      check(p >= 4, 1);
      ext_pin <= 9'h000;
      apb(0, `PMC_OFF_MODE, 0);
      check(rd, 0);
      $display("power-down test done");
    end
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_div;
    t_regs;
    t_idle;
    t_pdown;
    wrap_up;
  end
endmodule // pmc_top_tb_top
